// File: core/pdeo_pkg.sv
// Shared types and constants for the Port D / Port E alternate-function override logic
package pdeo_pkg;

  // Override set for one pin: each enable picks its paired value over the port register
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic dir_override_en;
    logic dir_override_val;
    logic outval_override_en;
    logic outval_override_val;
    logic input_en_override_en;
    logic input_en_override_val;
  } pdeo_ovr_type;

  // Port register view of one 8-bit port
  typedef struct packed {
    logic [7:0] out_bits;
    logic [7:0] dir_bits;
  } pdeo_port_type;

  localparam int PORT_WIDTH = 8;

  // Port D bit positions
  localparam int PD_CAPTURE_BIT = 0;
  localparam int PD_IRQ0_BIT = 1;

  // Port E bit positions
  localparam int PE_RX_BIT = 0;
  localparam int PE_TX_BIT = 1;
  localparam int PE_XCK_BIT = 2;
  localparam int PE_CMP_NEG_BIT = 3;
  localparam int PE_USI_CLK_BIT = 4;
  localparam int PE_USI_DI_BIT = 5;
  localparam int PE_USI_DO_BIT = 6;
  localparam int PE_DIVIDED_CLOCK_OUT_BIT = 7;

  // Values after reset
  localparam logic RST_PIN_BIT = 1'h0;
  localparam logic [7:0] RST_PORT_BYTE = 8'h00;
  localparam pdeo_ovr_type RST_OVR = '0;

  // Divided clock output: half period in I/O clock cycles
  localparam int DIVIDED_CLOCK_OUT_HALF_PERIOD = 1;
  localparam int DIVIDED_CLOCK_OUT_CNT_WIDTH = 8;

endpackage

// File: core/pdeo_pin_cell.sv
// One pad cell: applies pin overrides, synchronises the pad level, gates the digital input
`timescale 1ns/10ps

module pdeo_pin_cell (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire pdeo_pkg::pdeo_ovr_type ovr_in,
  input wire logic port_out_in,
  input wire logic port_dir_in,
  input wire logic pullup_disable_in,
  input wire logic pad_in,
  output logic pad_out_out,
  output logic pad_oe_out,
  output logic pullup_out,
  output logic digital_in_out
);

  logic sync_first;
  logic sync_second;
  logic next_pad_out;
  logic next_pad_oe;
  logic next_pullup;
  logic next_digital_in;
  logic input_enabled;

  // Resolve overrides against the port register bits
  always_comb begin
    // Each override value replaces the register setting only while its enable is high
    next_pad_oe = ovr_in.dir_override_en ? ovr_in.dir_override_val : port_dir_in;
    next_pad_out = ovr_in.outval_override_en ? ovr_in.outval_override_val : port_out_in;
    if (ovr_in.pullup_override_en) begin
      next_pullup = ovr_in.pullup_override_val;
    end else begin
      // Normal pull-up: input pin with its output bit set and pull-ups allowed
      next_pullup = port_out_in & ~next_pad_oe & ~pullup_disable_in;
    end
    // Digital input path on unless overridden off
    input_enabled = ovr_in.input_en_override_en ? ovr_in.input_en_override_val : 1'h1;
    // Only the second synchroniser stage is looked at
    next_digital_in = input_enabled ? sync_second : 1'h0;
  end

  // Pad level is asynchronous to the I/O clock, two flops before use
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_first <= pdeo_pkg::RST_PIN_BIT;
      sync_second <= pdeo_pkg::RST_PIN_BIT;
      pad_out_out <= pdeo_pkg::RST_PIN_BIT;
      pad_oe_out <= pdeo_pkg::RST_PIN_BIT;
      pullup_out <= pdeo_pkg::RST_PIN_BIT;
      digital_in_out <= pdeo_pkg::RST_PIN_BIT;
    end else begin
      sync_first <= pad_in;
      sync_second <= sync_first;
      pad_out_out <= next_pad_out;
      pad_oe_out <= next_pad_oe;
      pullup_out <= next_pullup;
      digital_in_out <= next_digital_in;
    end
  end

endmodule

// File: core/pdeo_pin_mux.sv
// Port D and Port E alternate-function override and routing to on-chip peripherals
`timescale 1ns/10ps

// Summary of operation
// - Port D bits 7..2 drive LCD front planes 19..24 (large) or 15..20 (small).
// - Port D bit 1 feeds external interrupt 0; also LCD front plane 25/21.
// - Port D bit 0 feeds timer 1 input capture; also LCD front plane 26/22.
// - Port D 7..4: LCD on and masked forces pull-up, direction, input enable to 0.
// - Bits 3,2,0 alike; bit 1 input enable by LCD or irq0, value both.
// - Port E bits 7..0 deliver synchronised levels as pin-change sources 7..0.
// - Clock-out fuse makes Port E bit 7 drive the divided clock.
// - Divided clock keeps running on Port E bit 7 while the device is in reset.
// - Port E bit 6 carries serial data out when the serial interface drives it.
// - Port E bit 5 is serial data in, and SDA in two-wire mode.
// - Port E bit 4 is serial clock, and SCL in two-wire mode.
// - Port E bit 3 goes straight to the comparator negative input.
// - Port E bit 2 is USART external clock and comparator positive input.
// - Port E bit 1 is the USART transmit output.
// - Port E bit 0 is the USART receive input.
// - Clock output active: direction override 1, output value the divided clock.
// - Receiver on: bit 0 forced input, output bit turns on the pull-up.
module pdeo_pin_mux #(
  parameter int DIVIDED_CLOCK_OUT_HALF = pdeo_pkg::DIVIDED_CLOCK_OUT_HALF_PERIOD
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic device_reset_in,
  input wire logic pullup_disable_in,
  input wire pdeo_pkg::pdeo_port_type port_d_in,
  input wire pdeo_pkg::pdeo_port_type port_e_in,
  input wire logic [7:0] pad_d_in,
  input wire logic [7:0] pad_e_in,
  input wire logic lcd_driver_on_in,
  input wire logic [7:0] lcd_port_mask_in,
  input wire logic ext_irq0_enable_in,
  input wire logic [7:0] pin_change_mask_in,
  input wire logic pin_change_enable_in,
  input wire logic clock_out_fuse_in,
  input wire logic usi_two_wire_in,
  input wire logic usi_three_wire_in,
  input wire logic usi_data_out_in,
  input wire logic usi_sda_out_in,
  input wire logic usi_scl_hold_in,
  input wire logic usi_start_irq_en_in,
  input wire logic usart_tx_en_in,
  input wire logic usart_tx_data_in,
  input wire logic usart_rx_en_in,
  input wire logic usart_xck_oe_in,
  input wire logic usart_xck_in,
  input wire logic comparator_neg_dis_in,
  input wire logic comparator_pos_dis_in,
  output logic [7:0] pad_d_out_out,
  output logic [7:0] pad_d_oe_out,
  output logic [7:0] pad_d_pullup_out,
  output logic [7:0] pad_e_out_out,
  output logic [7:0] pad_e_oe_out,
  output logic [7:0] pad_e_pullup_out,
  output logic [7:0] segment_line_out,
  output logic [7:0] port_d_digital_in_out,
  output logic [7:0] port_e_digital_in_out,
  output logic ext_irq0_out,
  output logic capture_in1_out,
  output logic [7:0] pin_change_irq_out,
  output logic usi_data_in_out,
  output logic usi_clock_out,
  output logic usart_rx_out,
  output logic usart_ext_clock_out,
  output logic comparator_neg_in_out,
  output logic comparator_pos_in_out
);

  localparam int W = pdeo_pkg::PORT_WIDTH;

  pdeo_pkg::pdeo_ovr_type ovr_d [W];
  pdeo_pkg::pdeo_ovr_type ovr_e [W];
  pdeo_pkg::pdeo_port_type eff_d;
  pdeo_pkg::pdeo_port_type eff_e;
  logic [pdeo_pkg::DIVIDED_CLOCK_OUT_CNT_WIDTH-1:0] divided_clock_out_cnt;
  logic [pdeo_pkg::DIVIDED_CLOCK_OUT_CNT_WIDTH-1:0] next_divided_clock_out_cnt;
  logic divided_clock_out;
  logic next_divided_clock_out;
  logic [7:0] segment_line;
  logic [7:0] next_segment_line;
  logic lcd_take_d;
  logic pcint_on;
  logic pcint_take [W];

  // Device reset returns the port registers to their reset values
  always_comb begin
    eff_d.out_bits = device_reset_in ? pdeo_pkg::RST_PORT_BYTE : port_d_in.out_bits;
    eff_d.dir_bits = device_reset_in ? pdeo_pkg::RST_PORT_BYTE : port_d_in.dir_bits;
    eff_e.out_bits = device_reset_in ? pdeo_pkg::RST_PORT_BYTE : port_e_in.out_bits;
    eff_e.dir_bits = device_reset_in ? pdeo_pkg::RST_PORT_BYTE : port_e_in.dir_bits;
  end

  // Port D overrides: LCD segment pins, with bit 1 shared by the external interrupt
  always_comb begin
    lcd_take_d = 1'h0;
    for (int i = 0; i < W; i++) begin
      ovr_d[i] = pdeo_pkg::RST_OVR;
      lcd_take_d = lcd_driver_on_in & lcd_port_mask_in[i] & ~device_reset_in;
      // Pull-up, direction, input enable overridden to 0, output value never
      ovr_d[i].pullup_override_en = lcd_take_d;
      ovr_d[i].dir_override_en = lcd_take_d;
      ovr_d[i].input_en_override_en = lcd_take_d;
      ovr_d[i].input_en_override_val = 1'h0;
      if (i == pdeo_pkg::PD_IRQ0_BIT) begin
        // Interrupt input is cut off when exactly one of the LCD driver and the interrupt enable is on
        ovr_d[i].input_en_override_en = lcd_driver_on_in | ext_irq0_enable_in;
        ovr_d[i].input_en_override_val = lcd_driver_on_in & ext_irq0_enable_in;
      end
    end
  end

  // Segment drive follows the same condition as the pad takeover
  always_comb begin
    for (int i = 0; i < W; i++) begin
      // Front planes 19..26 or 15..22 depending on pinout
      next_segment_line[i] = lcd_driver_on_in & lcd_port_mask_in[i] & ~device_reset_in;
    end
  end

  // Divided clock: toggles every DIVIDED_CLOCK_OUT_HALF cycles, independent of device reset
  always_comb begin
    next_divided_clock_out_cnt = divided_clock_out_cnt + 1'h1;
    next_divided_clock_out = divided_clock_out;
    if (divided_clock_out_cnt == pdeo_pkg::DIVIDED_CLOCK_OUT_CNT_WIDTH'(DIVIDED_CLOCK_OUT_HALF - 1)) begin
      next_divided_clock_out_cnt = '0;
      next_divided_clock_out = ~divided_clock_out;
    end
  end

  // Only the block power reset stops the divider, device reset does not
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      divided_clock_out_cnt <= '0;
      divided_clock_out <= pdeo_pkg::RST_PIN_BIT;
      segment_line <= pdeo_pkg::RST_PORT_BYTE;
    end else begin
      divided_clock_out_cnt <= next_divided_clock_out_cnt;
      divided_clock_out <= next_divided_clock_out;
      segment_line <= next_segment_line;
    end
  end

  assign segment_line_out = segment_line;

  // Port E overrides: clock out, serial interfaces, USART and comparator
  always_comb begin
    pcint_on = pin_change_enable_in & ~device_reset_in;
    for (int i = 0; i < W; i++) begin
      ovr_e[i] = pdeo_pkg::RST_OVR;
      pcint_take[i] = pin_change_mask_in[i] & pcint_on;
      // A masked pin-change source keeps its input path open
      ovr_e[i].input_en_override_en = pcint_take[i];
      ovr_e[i].input_en_override_val = 1'h1;
    end
    // Bit 7: fuse forces output of the divided clock, even during reset
    ovr_e[pdeo_pkg::PE_DIVIDED_CLOCK_OUT_BIT].dir_override_en = clock_out_fuse_in;
    ovr_e[pdeo_pkg::PE_DIVIDED_CLOCK_OUT_BIT].dir_override_val = 1'h1;
    ovr_e[pdeo_pkg::PE_DIVIDED_CLOCK_OUT_BIT].outval_override_en = clock_out_fuse_in;
    ovr_e[pdeo_pkg::PE_DIVIDED_CLOCK_OUT_BIT].outval_override_val = divided_clock_out;
    if (!device_reset_in) begin
      // Bit 6: three-wire mode drives data out
      ovr_e[pdeo_pkg::PE_USI_DO_BIT].outval_override_en = usi_three_wire_in;
      ovr_e[pdeo_pkg::PE_USI_DO_BIT].outval_override_val = usi_data_out_in;
      // Bit 5: two-wire SDA is open drain, only ever pulls low
      ovr_e[pdeo_pkg::PE_USI_DI_BIT].pullup_override_en = usi_two_wire_in;
      ovr_e[pdeo_pkg::PE_USI_DI_BIT].dir_override_en = usi_two_wire_in;
      ovr_e[pdeo_pkg::PE_USI_DI_BIT].dir_override_val =
        (~usi_sda_out_in | eff_e.out_bits[pdeo_pkg::PE_USI_DI_BIT])
        & eff_e.dir_bits[pdeo_pkg::PE_USI_DI_BIT];
      ovr_e[pdeo_pkg::PE_USI_DI_BIT].outval_override_en =
        usi_two_wire_in & eff_e.dir_bits[pdeo_pkg::PE_USI_DI_BIT];
      ovr_e[pdeo_pkg::PE_USI_DI_BIT].input_en_override_en =
        pcint_take[pdeo_pkg::PE_USI_DI_BIT] | usi_start_irq_en_in;
      // Bit 4: two-wire SCL, held low while the interface stretches the clock
      ovr_e[pdeo_pkg::PE_USI_CLK_BIT].pullup_override_en = usi_two_wire_in;
      ovr_e[pdeo_pkg::PE_USI_CLK_BIT].dir_override_en = usi_two_wire_in;
      ovr_e[pdeo_pkg::PE_USI_CLK_BIT].dir_override_val =
        (usi_scl_hold_in | eff_e.out_bits[pdeo_pkg::PE_USI_CLK_BIT])
        & eff_e.dir_bits[pdeo_pkg::PE_USI_CLK_BIT];
      ovr_e[pdeo_pkg::PE_USI_CLK_BIT].outval_override_en =
        usi_two_wire_in & eff_e.dir_bits[pdeo_pkg::PE_USI_CLK_BIT];
      ovr_e[pdeo_pkg::PE_USI_CLK_BIT].input_en_override_en =
        pcint_take[pdeo_pkg::PE_USI_CLK_BIT] | usi_start_irq_en_in;
      // Bit 3: comparator input may switch the digital buffer off
      ovr_e[pdeo_pkg::PE_CMP_NEG_BIT].input_en_override_en =
        pcint_take[pdeo_pkg::PE_CMP_NEG_BIT] | comparator_neg_dis_in;
      ovr_e[pdeo_pkg::PE_CMP_NEG_BIT].input_en_override_val = pcint_take[pdeo_pkg::PE_CMP_NEG_BIT];
      // Bit 2: external clock pull-up control and comparator positive input
      ovr_e[pdeo_pkg::PE_XCK_BIT].pullup_override_en = usart_xck_oe_in;
      ovr_e[pdeo_pkg::PE_XCK_BIT].pullup_override_val = usart_xck_in;
      ovr_e[pdeo_pkg::PE_XCK_BIT].input_en_override_en =
        pcint_take[pdeo_pkg::PE_XCK_BIT] | comparator_pos_dis_in;
      ovr_e[pdeo_pkg::PE_XCK_BIT].input_en_override_val = pcint_take[pdeo_pkg::PE_XCK_BIT];
      // Bit 1: transmitter owns the pin as an output
      ovr_e[pdeo_pkg::PE_TX_BIT].pullup_override_en = usart_tx_en_in;
      ovr_e[pdeo_pkg::PE_TX_BIT].dir_override_en = usart_tx_en_in;
      ovr_e[pdeo_pkg::PE_TX_BIT].dir_override_val = 1'h1;
      ovr_e[pdeo_pkg::PE_TX_BIT].outval_override_en = usart_tx_en_in;
      ovr_e[pdeo_pkg::PE_TX_BIT].outval_override_val = usart_tx_data_in;
      // Bit 0: receiver forces input, output bit selects the pull-up
      ovr_e[pdeo_pkg::PE_RX_BIT].pullup_override_en = usart_rx_en_in;
      ovr_e[pdeo_pkg::PE_RX_BIT].pullup_override_val =
        eff_e.out_bits[pdeo_pkg::PE_RX_BIT] & ~pullup_disable_in;
      ovr_e[pdeo_pkg::PE_RX_BIT].dir_override_en = usart_rx_en_in;
      ovr_e[pdeo_pkg::PE_RX_BIT].dir_override_val = 1'h0;
    end
  end

  // One pad cell per pin; all sixteen share the same override resolution
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      pdeo_pin_cell u_cell_d (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ovr_in(ovr_d[g]),
        .port_out_in(eff_d.out_bits[g]),
        .port_dir_in(eff_d.dir_bits[g]),
        .pullup_disable_in(pullup_disable_in),
        .pad_in(pad_d_in[g]),
        .pad_out_out(pad_d_out_out[g]),
        .pad_oe_out(pad_d_oe_out[g]),
        .pullup_out(pad_d_pullup_out[g]),
        .digital_in_out(port_d_digital_in_out[g])
      );
      pdeo_pin_cell u_cell_e (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ovr_in(ovr_e[g]),
        .port_out_in(eff_e.out_bits[g]),
        .port_dir_in(eff_e.dir_bits[g]),
        .pullup_disable_in(pullup_disable_in),
        .pad_in(pad_e_in[g]),
        .pad_out_out(pad_e_out_out[g]),
        .pad_oe_out(pad_e_oe_out[g]),
        .pullup_out(pad_e_pullup_out[g]),
        .digital_in_out(port_e_digital_in_out[g])
      );
    end
  endgenerate

  // Peripheral inputs read the synchronised, gated levels from the cells
  assign ext_irq0_out = port_d_digital_in_out[pdeo_pkg::PD_IRQ0_BIT];
  assign capture_in1_out = port_d_digital_in_out[pdeo_pkg::PD_CAPTURE_BIT];
  assign pin_change_irq_out = port_e_digital_in_out;
  assign usi_data_in_out = port_e_digital_in_out[pdeo_pkg::PE_USI_DI_BIT];
  assign usi_clock_out = port_e_digital_in_out[pdeo_pkg::PE_USI_CLK_BIT];
  assign usart_rx_out = port_e_digital_in_out[pdeo_pkg::PE_RX_BIT];
  assign usart_ext_clock_out = port_e_digital_in_out[pdeo_pkg::PE_XCK_BIT];

  // Comparator inputs are analog paths, so they bypass synchroniser and gating
  assign comparator_neg_in_out = pad_e_in[pdeo_pkg::PE_CMP_NEG_BIT];
  assign comparator_pos_in_out = pad_e_in[pdeo_pkg::PE_XCK_BIT];

endmodule

// File: verification/pdeo_pin_mux_properties.sv
// Concurrent checks on the ports of the Port D / Port E override block
`timescale 1ns/10ps
module pdeo_pin_mux_properties #(
  parameter int DIVIDED_CLOCK_OUT_HALF = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic device_reset_in,
  input wire logic pullup_disable_in,
  input wire pdeo_pkg::pdeo_port_type port_d_in,
  input wire pdeo_pkg::pdeo_port_type port_e_in,
  input wire logic [7:0] pad_e_in,
  input wire logic lcd_driver_on_in,
  input wire logic [7:0] lcd_port_mask_in,
  input wire logic ext_irq0_enable_in,
  input wire logic clock_out_fuse_in,
  input wire logic usart_tx_en_in,
  input wire logic usart_tx_data_in,
  input wire logic usart_rx_en_in,
  input wire logic [7:0] pad_d_out_out,
  input wire logic [7:0] pad_d_oe_out,
  input wire logic [7:0] pad_d_pullup_out,
  input wire logic [7:0] pad_e_out_out,
  input wire logic [7:0] pad_e_oe_out,
  input wire logic [7:0] pad_e_pullup_out,
  input wire logic [7:0] segment_line_out,
  input wire logic [7:0] port_d_digital_in_out,
  input wire logic ext_irq0_out,
  input wire logic capture_in1_out,
  input wire logic [7:0] pin_change_irq_out,
  input wire logic comparator_neg_in_out,
  input wire logic comparator_pos_in_out
);
  logic [2:0] up_cnt;
  logic [2:0] next_up_cnt;
  // Cycles since reset release; synchronisers hold stale zeros until it saturates
  always_comb begin
    next_up_cnt = (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt <= 3'h0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Output side of each pin follows overrides one cycle later
  a_seg_follow: assert property (!device_reset_in |=> segment_line_out ==
    ($past(lcd_driver_on_in) ? $past(lcd_port_mask_in) : 8'h00))
    else $error("segment drive wrong");
  a_lcd_pin_release: assert property (!device_reset_in && lcd_driver_on_in |=>
    ((pad_d_oe_out | pad_d_pullup_out) & $past(lcd_port_mask_in)) == 8'h00)
    else $error("LCD pin still driven or pulled up");
  a_port_d_regs: assert property (!device_reset_in && !lcd_driver_on_in |=>
    pad_d_oe_out == $past(port_d_in.dir_bits) && pad_d_out_out == $past(port_d_in.out_bits))
    else $error("port D pads differ from port registers");
  a_lcd_input_gate: assert property (
    (!device_reset_in && lcd_driver_on_in
    && !ext_irq0_enable_in && lcd_port_mask_in == 8'hFF)[*4] |->
    port_d_digital_in_out == 8'h00 && !ext_irq0_out && !capture_in1_out)
    else $error("digital input open under LCD");
  a_divided_clock_out_drive: assert property (clock_out_fuse_in |=> pad_e_oe_out[7])
    else $error("clock output pin not driven");
  a_divided_clock_out_toggle: assert property ((DIVIDED_CLOCK_OUT_HALF == 1 && clock_out_fuse_in)[*3] |->
    pad_e_out_out[7] != $past(pad_e_out_out[7])) else $error("clock output not toggling");
  a_tx_drive: assert property (usart_tx_en_in && !device_reset_in |=>
    pad_e_oe_out[1] && pad_e_out_out[1] == $past(usart_tx_data_in))
    else $error("transmit pin wrong");
  a_rx_input: assert property (usart_rx_en_in && !device_reset_in |=>
    !pad_e_oe_out[0]
    && pad_e_pullup_out[0] == ($past(port_e_in.out_bits[0]) && !$past(pullup_disable_in)))
    else $error("receive pin not input with pull-up");
  a_pin_change_sync: assert property (
    (up_cnt == 3'h7 && $stable(pad_e_in))[*4] |->
    (pin_change_irq_out & 8'hF3) == (pad_e_in & 8'hF3)) else $error("pin change level wrong");
  a_cmp_direct: assert property (comparator_neg_in_out == pad_e_in[3] &&
    comparator_pos_in_out == pad_e_in[2]) else $error("comparator inputs not direct");
  c_divided_clock_out_in_reset: cover property (clock_out_fuse_in && device_reset_in);
  c_lcd_irq0: cover property (lcd_driver_on_in && ext_irq0_enable_in);
  c_usart_both: cover property (usart_rx_en_in && usart_tx_en_in);
endmodule

bind pdeo_pin_mux pdeo_pin_mux_properties #(.DIVIDED_CLOCK_OUT_HALF(DIVIDED_CLOCK_OUT_HALF)) u_pdeo_props (.*);

// File: verification/pdeo_periph_model.sv
// Peripheral-side stand-in: USART transmitter and serial data output sources
`timescale 1ns/10ps
module pdeo_periph_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic usart_tx_en_in,
  output logic usart_tx_data_out,
  output logic usi_data_out_out
);
  logic [3:0] shreg;
  logic [3:0] next_shreg;
  // Rotating pattern, so a stuck transmit path cannot match by luck
  always_comb begin
    next_shreg = usart_tx_en_in ? {shreg[2:0], shreg[3]} : shreg;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shreg <= 4'h6;
    end else begin
      shreg <= next_shreg;
    end
  end
  assign usart_tx_data_out = shreg[0];
  assign usi_data_out_out = shreg[1];
endmodule

// File: verification/pdeo_pin_mux_bench.sv
// Self-checking bench for the Port D / Port E override block
`timescale 1ns/10ps
module pdeo_pin_mux_bench;
  logic clk_in = 1'h0, nrst_in = 1'h0, device_reset_in = 1'h0, pullup_disable_in = 1'h0;
  logic lcd_driver_on_in = 1'h0, ext_irq0_enable_in = 1'h0, clock_out_fuse_in = 1'h0;
  logic pin_change_enable_in = 1'h0, usi_two_wire_in = 1'h0, usi_three_wire_in = 1'h0;
  logic usi_sda_out_in = 1'h0, usart_tx_en_in = 1'h0, usart_rx_en_in = 1'h0;
  logic comparator_neg_dis_in = 1'h0, comparator_pos_dis_in = 1'h0;
  // Start detector enable stays idle: it only keeps the serial inputs open, as they are anyway
  logic usi_scl_hold_in = 1'h0, usi_start_irq_en_in = 1'h0;
  logic usart_xck_oe_in = 1'h0, usart_xck_in = 1'h0;
  logic usi_data_out_in, usart_tx_data_in, prev;
  logic [7:0] lcd_port_mask_in = 8'h00, pin_change_mask_in = 8'h00, ext_d = 8'h00, ext_e = 8'h00;
  logic [7:0] pad_d_in, pad_e_in, pad_d_out_out, pad_d_oe_out, pad_d_pullup_out;
  logic [7:0] pad_e_out_out, pad_e_oe_out, pad_e_pullup_out, segment_line_out;
  logic [7:0] port_d_digital_in_out, port_e_digital_in_out, pin_change_irq_out;
  logic ext_irq0_out, capture_in1_out, usi_data_in_out, usi_clock_out, usart_rx_out;
  logic usart_ext_clock_out, comparator_neg_in_out, comparator_pos_in_out;
  pdeo_pkg::pdeo_port_type port_d_in = '0, port_e_in = '0;
  int n_mismatch = 0, checked = 0;
  // Pad level: the block drives where enabled, the board elsewhere
  assign pad_d_in = (pad_d_oe_out & pad_d_out_out) | (~pad_d_oe_out & ext_d);
  assign pad_e_in = (pad_e_oe_out & pad_e_out_out) | (~pad_e_oe_out & ext_e);
  always #10 clk_in = ~clk_in;
  pdeo_pin_mux #(.DIVIDED_CLOCK_OUT_HALF(1)) i_dut (.*);
  pdeo_periph_model i_periph (.clk_in(clk_in), .nrst_in(nrst_in), .usart_tx_en_in(usart_tx_en_in),
    .usart_tx_data_out(usart_tx_data_in), .usi_data_out_out(usi_data_out_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs always move 2 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic t_lcd();
    port_d_in = '{out_bits: 8'h3C, dir_bits: 8'hA5};
    step(1);
    chk(pad_d_oe_out, 8'hA5);
    chk(pad_d_out_out, 8'h3C);
    ext_d = 8'hFF;
    lcd_driver_on_in = 1'h1;
    lcd_port_mask_in = 8'h0F;
    step(1);
    chk(segment_line_out, 8'h0F);
    chk(pad_d_oe_out, 8'hA0);
    lcd_port_mask_in = 8'hFF;
    step(5);
    chk(pad_d_oe_out | pad_d_pullup_out, 8'h00);
    chk(port_d_digital_in_out, 8'h00);
    chk({6'h00, ext_irq0_out, capture_in1_out}, 8'h00);
    ext_irq0_enable_in = 1'h1;
    step(5);
    chk(port_d_digital_in_out, 8'h02);
    chk(ext_irq0_out, 1'h1);
    lcd_driver_on_in = 1'h0;
    port_d_in = '0;
    step(5);
    chk(ext_irq0_out, 1'h0);
    chk(capture_in1_out, 1'h1);
    ext_irq0_enable_in = 1'h0;
  endtask
  task automatic t_port_e_inputs();
    ext_e = 8'h5A;
    step(5);
    chk(pin_change_irq_out, 8'h5A);
    chk({comparator_neg_in_out, comparator_pos_in_out}, 8'h02);
    chk({usi_data_in_out, usi_clock_out}, 8'h01);
    chk(usart_rx_out, 1'h0);
    ext_e = 8'hA5;
    step(5);
    chk(pin_change_irq_out, 8'hA5);
    chk({comparator_neg_in_out, comparator_pos_in_out}, 8'h01);
    chk({usi_data_in_out, usi_clock_out}, 8'h02);
    chk({usart_rx_out, usart_ext_clock_out}, 8'h03);
    comparator_neg_dis_in = 1'h1;
    comparator_pos_dis_in = 1'h1;
    ext_e = 8'h0C;
    step(5);
    chk(port_e_digital_in_out & 8'h0C, 8'h00);
    pin_change_enable_in = 1'h1;
    pin_change_mask_in = 8'h0C;
    step(5);
    chk(port_e_digital_in_out & 8'h0C, 8'h0C);
    {comparator_neg_dis_in, comparator_pos_dis_in, pin_change_enable_in} = 3'h0;
  endtask
  task automatic t_divided_clock_out();
    clock_out_fuse_in = 1'h1;
    for (int r = 1; r >= 0; r--) begin
      device_reset_in = r[0];
      step(2);
      chk(pad_e_oe_out[7], 1'h1);
      prev = pad_e_out_out[7];
      step(1);
      // Inverse kept one bit wide, or it would widen to the task's byte
      chk(pad_e_out_out[7], {7'h00, ~prev});
    end
    clock_out_fuse_in = 1'h0;
    step(1);
    chk(pad_e_oe_out[7], 1'h0);
  endtask
  task automatic t_usart();
    usart_tx_en_in = 1'h1;
    step(1);
    prev = usart_tx_data_in;
    repeat (4) begin
      step(1);
      chk({pad_e_oe_out[1], pad_e_out_out[1]}, {6'h00, 1'h1, prev});
      prev = usart_tx_data_in;
    end
    usart_tx_en_in = 1'h0;
    usart_rx_en_in = 1'h1;
    port_e_in = '{out_bits: 8'h01, dir_bits: 8'h01};
    step(1);
    chk({pad_e_oe_out[0], pad_e_pullup_out[0]}, 8'h01);
    pullup_disable_in = 1'h1;
    step(1);
    chk(pad_e_pullup_out[0], 1'h0);
    {usart_rx_en_in, pullup_disable_in} = 2'h0;
    // External clock output enable hands the pull-up to the clock level
    {usart_xck_oe_in, usart_xck_in} = 2'h3;
    step(1);
    chk(pad_e_pullup_out[2], 1'h1);
    usart_xck_in = 1'h0;
    step(1);
    chk(pad_e_pullup_out[2], 1'h0);
    usart_xck_oe_in = 1'h0;
  endtask
  task automatic t_usi();
    usi_three_wire_in = 1'h1;
    // Register bit 6 set, so only the override can bring the serial data out
    port_e_in = '{out_bits: 8'h40, dir_bits: 8'h70};
    step(1);
    chk({pad_e_oe_out[6], pad_e_out_out[6]}, {6'h00, 1'h1, usi_data_out_in});
    usi_three_wire_in = 1'h0;
    usi_two_wire_in = 1'h1;
    step(1);
    chk(pad_e_oe_out & 8'h30, 8'h20);
    chk(pad_e_out_out[5], 1'h0);
    usi_sda_out_in = 1'h1;
    step(1);
    chk(pad_e_oe_out[5], 1'h0);
    usi_scl_hold_in = 1'h1;
    step(1);
    chk(pad_e_oe_out[4], 1'h1);
    {usi_two_wire_in, usi_scl_hold_in} = 2'h0;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence: reset for 5 cycles, then each scenario in turn
  initial begin
    step(5);
    chk(pad_d_oe_out | pad_e_oe_out, 8'h00);
    nrst_in = 1'h1;
    t_lcd();
    t_port_e_inputs();
    t_divided_clock_out();
    t_usart();
    t_usi();
    tally_and_finish();
  end
endmodule
